// ==== rtl/tkoh_pkg.sv ====
package tkoh_pkg;
  // Clock and timing.
  localparam int CLK_NS = 4;
  localparam int EXT_RST_NS = 10000;
  localparam int EXT_RST_CYC = (EXT_RST_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int STRAP_NS = 1000;
  localparam int STRAP_CYC = (STRAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_PULSE_NS = 32;
  localparam int INT_PULSE_CYC = INT_PULSE_NS / CLK_NS;
  localparam logic [3:0] PWM_LAST_STEP = 4'hE;
  // Register addresses.
  localparam logic [7:0] A_ID = 8'h02;
  localparam logic [7:0] A_CHEN = 8'h03;
  localparam logic [7:0] A_MODE = 8'h04;
  localparam logic [7:0] A_PINSEL = 8'h05;
  localparam logic [7:0] A_PERIOD = 8'h07;
  localparam logic [7:0] A_STAT = 8'h2A;
  localparam logic [7:0] A_CFG = 8'h3A;
  localparam logic [7:0] A_DIM = 8'h3B;
  localparam logic [7:0] A_SENS0 = 8'h40;
  localparam logic [7:0] A_SENS7 = 8'h47;
  localparam logic [7:0] A_LVL0 = 8'h48;
  localparam logic [7:0] A_LVL3 = 8'h4B;
  localparam logic [7:0] A_MON = 8'h4F;
  // Reset values.
  localparam logic [7:0] RST_ID_HI = 8'hB8;
  localparam logic [7:0] RST_ID_LO = 8'hB4;
  localparam logic [7:0] RST_CHEN = 8'hFF;
  localparam logic [7:0] RST_MODE = 8'h55;
  localparam logic [7:0] RST_PINSEL = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'h27;
  localparam logic [7:0] RST_CFG = 8'h05;
  localparam logic [7:0] RST_DIM = 8'h20;
  localparam logic [7:0] RST_MON = 8'h20;
  localparam logic [5:0] SENS_VDD = 6'h18;
  localparam logic [5:0] SENS_OPEN = 6'h0F;
  localparam logic [5:0] SENS_GND = 6'h0C;
  // Field positions.
  localparam int MODE_MULTI_BIT = 2;
  localparam int CFG_INT_MODE_BIT = 4;
  localparam int CFG_OUTPUT_POLARITY_SEL_BIT = 1;
  localparam int DIM_EN_BIT = 4;
  // Pads as seen through the synchroniser.
  typedef struct packed {
    logic scl;
    logic sda;
    logic ext_rst;
    logic strap_high;
    logic strap_low;
  } tkoh_pins_t;
  localparam tkoh_pins_t PINS_RST = '{scl: 1'b1, sda: 1'b1, default: 1'b0};
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_A, S_REG, S_ACK_R, S_WR, S_ACK_W, S_RD, S_RACK
  } tkoh_i2c_st_t;
endpackage

// ==== rtl/tkoh_top.sv ====
// Contract
// (R1) Touch when channel count exceeds reference threshold
// (R2) Each output follows its own channel
// (R3) Pins and status register valid together
// (R4) One polarity bit for all outputs
// (R5) Drive only toward active level
// (R6) Sixteen brightness levels per LED pin
// (R7) Level zero off, level fifteen on
// (R8) LED pins never show touch state
// (R9) Pin select, global enable, level registers
// (R10) Interrupt on touch status change
// (R11) Interrupt pin only pulls low
// (R12) Pulse or held-until-read interrupt modes
// (R13) High or open strap: address B8h, multi
// (R14) Ground strap: address B4h, single, 0Ch
// (R15) Strap sampled after reset, then applied
// (R16) Oscillator off while SCL, SDA high
// (R17) Master sends address after START
// (R18) Address last bit: 1 read, 0 write
// (R19) External reset held high over 10us
// (R20) Interrupt output is active low
// (R21) Write: address, register, data, acknowledged
// (R22) Read: pointer write, restart, NACK, STOP
`timescale 1ns/1ns
module tkoh_top import tkoh_pkg::*; #(
  parameter int CNT_W = 10,
  parameter int PWM_DIV = 256
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Measurement front end
  input wire logic [7:0][CNT_W-1:0] touch_sense_input,
  input wire logic [CNT_W-1:0] reference_cap_input,
  input wire logic meas_valid,
  // Pads
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ext_rst_i,
  input wire logic strap_high_i,
  input wire logic strap_low_i,
  // Pad drivers
  output logic sda_oe_r,
  output logic [7:0] direct_touch_output_r,
  output logic [7:0] direct_touch_output_oe_r,
  output logic int_n_oe_r,
  output logic osc_en_r
);
  tkoh_pins_t ff1_r, ff2_r, ff3_r, lv_r, lvq_r;
  logic [11:0] ext_cnt_r;
  logic [7:0] id_r, chen_r, mode_r, pinsel_r, period_r, cfg_r, dim_r, mon_r;
  logic [7:0][5:0] sens_r;
  logic [7:0][3:0] led_brightness_level_r;
  logic [7:0] touch_r, sh_r, tx_r, ptr_r;
  logic [8:0] strap_cnt_r;
  logic [3:0] bit_cnt_r, int_cnt_r, step_r;
  logic [15:0] div_r;
  logic ext_hit_r, strap_done_r, rw_r, nack_r, wr_stb_r, rd_stat_r;
  tkoh_i2c_st_t st_r;
  wire core_rst = !rst_b || ext_hit_r;
  wire [4:0] agree = ~(ff2_r ^ ff3_r);
  wire [4:0] lv_nxt = (lv_r & ~agree) | (ff3_r & agree);
  wire scl_rise = !lvq_r.scl && lv_r.scl;
  wire scl_fall = lvq_r.scl && !lv_r.scl;
  wire i2c_start = lvq_r.scl && lv_r.scl && lvq_r.sda && !lv_r.sda;
  wire i2c_stop = lvq_r.scl && lv_r.scl && !lvq_r.sda && lv_r.sda;
  wire byte_in = (bit_cnt_r == 4'h8);
  wire multi = mode_r[MODE_MULTI_BIT];
  wire output_polarity_sel = cfg_r[CFG_OUTPUT_POLARITY_SEL_BIT];
  wire int_level = cfg_r[CFG_INT_MODE_BIT];
  wire dim_en = dim_r[DIM_EN_BIT];
  wire strap_apply = !strap_done_r && (strap_cnt_r == 9'(STRAP_CYC - 1));
  wire [2:0] sens_idx = 3'(ptr_r - A_SENS0);
  wire [1:0] lvl_idx = 2'(ptr_r - A_LVL0);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ff1_r <= PINS_RST;
      ff2_r <= PINS_RST;
      ff3_r <= PINS_RST;
      lv_r <= PINS_RST;
      lvq_r <= PINS_RST;
    end else begin
      ff1_r <= '{scl_i, sda_i, ext_rst_i, strap_high_i, strap_low_i};
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      lv_r <= tkoh_pins_t'(lv_nxt);
      lvq_r <= lv_r;
    end
  end

  // (R19) long pulse resets
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !lv_r.ext_rst) begin
      ext_cnt_r <= '0;
      ext_hit_r <= 1'b0;
    end else begin
      if (ext_cnt_r != 12'(EXT_RST_CYC)) ext_cnt_r <= ext_cnt_r + 12'h001;
      ext_hit_r <= (ext_cnt_r == 12'(EXT_RST_CYC));
    end
  end

  // Touch decision, one comparator per channel.
  logic [7:0] raw;
  genvar g;
  for (g = 0; g < 8; g++) begin : g_ch
    wire [CNT_W:0] thr = {1'b0, reference_cap_input} + (CNT_W + 1)'(sens_r[g]);
    // (R1) rise over reference
    assign raw[g] = chen_r[g] && ({1'b0, touch_sense_input[g]} > thr);
  end
  // Single-touch mode keeps only the lowest touched channel.
  wire [7:0] sel = multi ? raw : (raw & (~raw + 8'h01));
  wire touch_chg = meas_valid && (sel != touch_r);

  // Register read selection.
  logic [7:0] rdata;
  always_comb begin
    rdata = 8'h00;
    unique case (1'b1)
      ptr_r == A_ID: rdata = id_r;
      ptr_r == A_CHEN: rdata = chen_r;
      ptr_r == A_MODE: rdata = mode_r;
      ptr_r == A_PINSEL: rdata = pinsel_r;
      ptr_r == A_PERIOD: rdata = period_r;
      ptr_r == A_STAT: rdata = touch_r;
      ptr_r == A_CFG: rdata = cfg_r;
      ptr_r == A_DIM: rdata = dim_r;
      ptr_r == A_MON: rdata = mon_r;
      ptr_r >= A_SENS0 && ptr_r <= A_SENS7: rdata = {2'b00, sens_r[sens_idx]};
      ptr_r >= A_LVL0 && ptr_r <= A_LVL3:
        rdata = {led_brightness_level_r[{lvl_idx, 1'b1}], led_brightness_level_r[{lvl_idx, 1'b0}]};
      default: rdata = 8'h00;
    endcase
  end

  // I2C slave, sampled on SCL rise and driven on SCL fall.
  always_ff @(posedge clk_sys) begin
    wr_stb_r <= 1'b0;
    rd_stat_r <= 1'b0;
    if (core_rst || i2c_stop) begin
      st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
      bit_cnt_r <= '0;
      if (core_rst) begin
        sh_r <= '0;
        tx_r <= '0;
        ptr_r <= '0;
        rw_r <= 1'b0;
        nack_r <= 1'b0;
      end
    end else if (i2c_start) begin
      // (R17) address follows start
      st_r <= S_ADDR;
      sda_oe_r <= 1'b0;
      bit_cnt_r <= '0;
    end else if (scl_rise) begin
      if (st_r == S_ADDR || st_r == S_REG || st_r == S_WR) begin
        sh_r <= {sh_r[6:0], lv_r.sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (st_r == S_RD) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (st_r == S_RACK) begin
        nack_r <= lv_r.sda;
      end
    end else if (scl_fall) begin
      unique case (st_r)
        S_IDLE: sda_oe_r <= 1'b0;
        S_ADDR: if (byte_in) begin
          bit_cnt_r <= '0;
          // (R18) direction bit
          rw_r <= sh_r[0];
          st_r <= (sh_r[7:1] == id_r[7:1]) ? S_ACK_A : S_IDLE;
          sda_oe_r <= (sh_r[7:1] == id_r[7:1]);
        end
        S_ACK_A: if (rw_r) begin
          // (R22) return pointed register
          st_r <= S_RD;
          tx_r <= rdata;
          sda_oe_r <= !rdata[7];
          rd_stat_r <= (ptr_r == A_STAT);
        end else begin
          st_r <= S_REG;
          sda_oe_r <= 1'b0;
        end
        S_REG: if (byte_in) begin
          bit_cnt_r <= '0;
          ptr_r <= sh_r;
          st_r <= S_ACK_R;
          sda_oe_r <= 1'b1;
        end
        S_ACK_R, S_ACK_W: begin
          st_r <= S_WR;
          sda_oe_r <= 1'b0;
        end
        S_WR: if (byte_in) begin
          // (R21) store and acknowledge
          bit_cnt_r <= '0;
          wr_stb_r <= 1'b1;
          st_r <= S_ACK_W;
          sda_oe_r <= 1'b1;
        end
        S_RD: if (byte_in) begin
          bit_cnt_r <= '0;
          st_r <= S_RACK;
          sda_oe_r <= 1'b0;
        end else begin
          tx_r <= {tx_r[6:0], 1'b0};
          sda_oe_r <= !tx_r[6];
        end
        S_RACK: begin
          st_r <= nack_r ? S_IDLE : S_ACK_A;
          sda_oe_r <= 1'b0;
          if (!nack_r) ptr_r <= ptr_r + 8'h01;
        end
        default: st_r <= S_IDLE;
      endcase
    end else if (wr_stb_r) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // Register file; the strap result lands once after reset.
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      id_r <= RST_ID_HI;
      chen_r <= RST_CHEN;
      mode_r <= RST_MODE;
      pinsel_r <= RST_PINSEL;
      period_r <= RST_PERIOD;
      cfg_r <= RST_CFG;
      dim_r <= RST_DIM;
      mon_r <= RST_MON;
      sens_r <= {8{SENS_OPEN}};
      led_brightness_level_r <= '0;
      strap_cnt_r <= '0;
      strap_done_r <= 1'b0;
    end else begin
      if (!strap_done_r) strap_cnt_r <= strap_cnt_r + 9'h001;
      // (R15) apply strap options
      if (strap_apply) begin
        strap_done_r <= 1'b1;
        // (R14) ground option
        id_r <= lv_r.strap_low ? RST_ID_LO : RST_ID_HI;
        // (R13) high or open option
        mode_r[MODE_MULTI_BIT] <= !lv_r.strap_low;
        sens_r <= lv_r.strap_low ? {8{SENS_GND}} : lv_r.strap_high ? {8{SENS_VDD}} :
          {8{SENS_OPEN}};
      end else if (wr_stb_r) begin
        // (R9) register writes, dimming control registers included
        unique case (1'b1)
          ptr_r == A_ID: id_r <= sh_r;
          ptr_r == A_CHEN: chen_r <= sh_r;
          ptr_r == A_MODE: mode_r <= sh_r;
          ptr_r == A_PINSEL: pinsel_r <= sh_r;
          ptr_r == A_PERIOD: period_r <= sh_r;
          ptr_r == A_CFG: cfg_r <= sh_r;
          ptr_r == A_DIM: dim_r <= sh_r;
          ptr_r == A_MON: mon_r <= sh_r;
          ptr_r >= A_SENS0 && ptr_r <= A_SENS7: sens_r[sens_idx] <= sh_r[5:0];
          ptr_r >= A_LVL0 && ptr_r <= A_LVL3: begin
            led_brightness_level_r[{lvl_idx, 1'b0}] <= sh_r[3:0];
            led_brightness_level_r[{lvl_idx, 1'b1}] <= sh_r[7:4];
          end
          default: ;
        endcase
      end
    end
  end

  // PWM: fifteen steps per period so level 15 never turns off.
  wire pwm_tick = (div_r == 16'(PWM_DIV - 1));
  logic [7:0] pwm_on;
  for (g = 0; g < 8; g++) begin : g_pwm
    // (R7) duty from 0 to 100
    assign pwm_on[g] = (step_r < led_brightness_level_r[g]);
  end
  wire [7:0] led_mask = dim_en ? pinsel_r : 8'h00;
  // (R8) LED pins drop touch
  wire [7:0] oe_nxt = (touch_r & ~led_mask) | (pwm_on & led_mask);
  // (R5) LED pins sink, others drive the active level
  wire [7:0] lvl_nxt = output_polarity_sel ? ~led_mask : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      div_r <= '0;
      step_r <= '0;
      touch_r <= '0;
      direct_touch_output_r <= '0;
      direct_touch_output_oe_r <= '0;
      int_n_oe_r <= 1'b0;
      int_cnt_r <= '0;
      osc_en_r <= 1'b1;
    end else begin
      div_r <= pwm_tick ? 16'h0000 : div_r + 16'h0001;
      // (R6) fifteen-step counter (0 to 14) for sixteen levels
      if (pwm_tick) step_r <= (step_r == PWM_LAST_STEP) ? 4'h0 : step_r + 4'h1;
      // (R3) one status for pins and bus
      if (meas_valid) touch_r <= sel;
      // (R2) per-channel pin drive
      direct_touch_output_oe_r <= oe_nxt;
      // (R4) common polarity
      direct_touch_output_r <= lvl_nxt;
      // (R11) (R20) pull low only
      // (R10) change raises interrupt; set beats clear
      if (touch_chg) begin
        int_n_oe_r <= 1'b1;
        int_cnt_r <= 4'(INT_PULSE_CYC - 1);
      end else if (int_level) begin
        // (R12) held until status read
        if (rd_stat_r) int_n_oe_r <= 1'b0;
      end else if (int_cnt_r != 4'h0) begin
        int_cnt_r <= int_cnt_r - 4'h1;
      end else begin
        int_n_oe_r <= 1'b0;
      end
      // (R16) idle bus stops oscillator
      osc_en_r <= !(lv_r.scl && lv_r.sda);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (core_rst);
  sequence s_chg_seen;
    touch_chg ##1 int_n_oe_r;
  endsequence
  property p_int_set;
    touch_chg |-> s_chg_seen;
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt missed a change"); // (R10)
  sequence s_pulse_quiet;
    (!touch_chg && !int_level)[*8];
  endsequence
  property p_int_pulse;
    touch_chg && !int_level |=> int_n_oe_r[*8];
  endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("pulse width wrong"); // (R12)
  // A new change restarts the pulse, so the end is only checked after a quiet stretch.
  property p_int_end;
    (touch_chg && !int_level) ##1 s_pulse_quiet |=> !int_n_oe_r;
  endproperty
  a_int_end: assert property (p_int_end) else $error("pulse did not end"); // (R12)
  property p_int_hold;
    int_level && int_n_oe_r && !rd_stat_r && !touch_chg |=> int_n_oe_r;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("level interrupt dropped"); // (R12)
  property p_direct;
    !dim_en |=> direct_touch_output_oe_r == $past(touch_r);
  endproperty
  a_direct: assert property (p_direct) else $error("direct pin mismatch"); // (R2)
  property p_pol;
    !dim_en |=> direct_touch_output_r == {8{$past(output_polarity_sel)}};
  endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong"); // (R4)
  property p_excl;
    dim_en && pinsel_r[0] && step_r >= led_brightness_level_r[0] |=>
      !direct_touch_output_oe_r[0];
  endproperty
  a_excl: assert property (p_excl) else $error("led pin shows touch"); // (R8)
  property p_full;
    dim_en && pinsel_r[0] && led_brightness_level_r[0] == 4'hF |=> direct_touch_output_oe_r[0];
  endproperty
  a_full: assert property (p_full) else $error("full level not on"); // (R7)
  property p_osc;
    lv_r.scl && lv_r.sda |=> !osc_en_r;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator runs on idle bus"); // (R16)
  property p_addr_ack;
    scl_fall && st_r == S_ADDR && byte_in |=> sda_oe_r == (sh_r[7:1] == id_r[7:1]);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong"); // (R18)
  property p_strap;
    strap_apply && lv_r.strap_low |=> id_r == RST_ID_LO && !mode_r[MODE_MULTI_BIT];
  endproperty
  a_strap: assert property (p_strap) else $error("ground strap not applied"); // (R14)
endmodule // tkoh_top

// ==== sim/tkoh_i2c_master.sv ====
`timescale 1ns/1ns
module tkoh_i2c_master #(
  parameter int HALF = 16
) (
  // Clock
  input wire logic clk_sys,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic start();
    sda_low = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b0;
    hold(HALF);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b0;
    hold(HALF);
  endtask
  // Data moves well after the clock fall, so the synchronised lines never show a false START.
  task automatic bit_cycle(input logic b, output logic seen);
    sda_low = ~b;
    hold(HALF);
    scl = 1'b1;
    hold(HALF / 2);
    seen = sda;
    hold(HALF - HALF / 2);
    scl = 1'b0;
    hold(6);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, ack_n);
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(last, s);
  endtask
  task automatic write_reg(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d,
                           output logic [2:0] ack_n);
    start();
    send_byte(dev & 8'hFE, ack_n[2]);
    send_byte(ra, ack_n[1]);
    send_byte(d, ack_n[0]);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] dev, input logic [7:0] ra, output logic [7:0] d,
                          output logic [2:0] ack_n);
    start();
    send_byte(dev & 8'hFE, ack_n[2]);
    send_byte(ra, ack_n[1]);
    start();
    send_byte(dev | 8'h01, ack_n[0]);
    recv_byte(1'b1, d);
    stop();
  endtask
endmodule // tkoh_i2c_master

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top import tkoh_pkg::*;;
  localparam int CW = 10;
  localparam logic [7:0] DEV = 8'hB8;
  logic clk_sys;
  logic rst_b;
  logic [7:0][CW-1:0] sense;
  logic [CW-1:0] ref_cnt;
  logic meas_valid;
  logic scl;
  logic sda_low;
  wire logic sda;
  logic sda_oe_r;
  logic [7:0] pin_r;
  logic [7:0] pin_oe;
  logic int_oe;
  logic osc;
  logic ack1;
  logic ext_rst;
  logic strap_low;
  logic [7:0] dev;
  int fail_count;
  int checks;
  int c;
  // The pull-up wins unless some party pulls the line low.
  assign sda = ~(sda_low | sda_oe_r);
  tkoh_top #(.CNT_W(CW), .PWM_DIV(2)) tkoh_top_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .touch_sense_input(sense),
    .reference_cap_input(ref_cnt), .meas_valid(meas_valid), .scl_i(scl), .sda_i(sda),
    .ext_rst_i(ext_rst), .strap_high_i(1'b0), .strap_low_i(strap_low), .sda_oe_r(sda_oe_r),
    .direct_touch_output_r(pin_r), .direct_touch_output_oe_r(pin_oe),
    .int_n_oe_r(int_oe), .osc_en_r(osc)
  );
  tkoh_i2c_master tkoh_i2c_master_inst (.clk_sys(clk_sys), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rd(input string what, input logic [7:0] ra, input logic [7:0] exp);
    logic [7:0] d;
    logic [2:0] a;
    tkoh_i2c_master_inst.read_reg(dev, ra, d, a);
    check("read ack", 16'(a), 16'h0000);
    check(what, 16'(d), 16'(exp));
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic [2:0] a;
    tkoh_i2c_master_inst.write_reg(dev, ra, d, a);
    check("write ack", 16'(a), 16'h0000);
  endtask
  // Untouched channels sit exactly on the threshold, which must not count as a touch.
  task automatic measure(input logic [7:0] hit);
    @(negedge clk_sys);
    for (int g = 0; g < 8; g++) sense[g] = ref_cnt + CW'(SENS_OPEN) + CW'(hit[g]);
    meas_valid = 1'b1;
    @(negedge clk_sys);
    meas_valid = 1'b0;
  endtask
  task automatic count_led(output int n);
    n = 0;
    repeat (60) begin
      @(negedge clk_sys);
      if (pin_oe[0] === 1'b1) n++;
    end
  endtask
  task automatic pulse_len(output int n);
    n = 0;
    for (int i = 0; i < 4 && int_oe !== 1'b1; i++) @(negedge clk_sys);
    while (int_oe === 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
  endtask
  initial begin
    rst_b = 1'b0;
    sense = '0;
    ref_cnt = 10'h064;
    meas_valid = 1'b0;
    fail_count = 0;
    checks = 0;
    ext_rst = 1'b0;
    strap_low = 1'b0;
    dev = DEV;
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    check("reset drivers", {6'h00, sda_oe_r, int_oe, pin_oe}, 16'h0000);
    repeat (STRAP_CYC + 20) @(negedge clk_sys);
    check("osc idle", 16'(osc), 16'h0000);
    rd("address", A_ID, RST_ID_HI);
    rd("mode", A_MODE, RST_MODE);
    rd("sensitivity", A_SENS0 + 8'h03, {2'b00, SENS_OPEN});
    rd("unmapped", 8'h60, 8'h00);
    tkoh_i2c_master_inst.start();
    repeat (8) @(negedge clk_sys);
    check("osc busy", 16'(osc), 16'h0001);
    tkoh_i2c_master_inst.send_byte(8'hB4, ack1);
    check("foreign address nack", 16'(ack1), 16'h0001);
    tkoh_i2c_master_inst.stop();
    measure(8'h21);
    pulse_len(c);
    check("pulse length", 16'(c), 16'(INT_PULSE_CYC));
    rd("status", A_STAT, 8'h21);
    check("pins driven", 16'(pin_oe), 16'h0021);
    check("active low", 16'(pin_r & pin_oe), 16'h0000);
    wr(A_CFG, 8'h07);
    check("pins driven high", 16'(pin_oe), 16'h0021);
    check("active high", 16'(pin_r & pin_oe), 16'h0021);
    wr(A_CFG, 8'h17);
    measure(8'h20);
    repeat (40) @(negedge clk_sys);
    check("held interrupt", 16'(int_oe), 16'h0001);
    rd("status", A_STAT, 8'h20);
    repeat (4) @(negedge clk_sys);
    check("interrupt cleared", 16'(int_oe), 16'h0000);
    measure(8'h21);
    wr(A_PINSEL, 8'h01);
    check("dimming off", 16'(pin_oe), 16'h0021);
    wr(A_DIM, 8'h30);
    count_led(c);
    check("level 0 duty", 16'(c), 16'h0000);
    check("other pin", 16'(pin_oe & 8'h20), 16'h0020);
    wr(A_LVL0, 8'h0F);
    count_led(c);
    check("level 15 duty", 16'(c), 16'h003C);
    wr(A_LVL0, 8'h08);
    count_led(c);
    check("level 8 duty", 16'(c), 16'h0020);
    // the strap moves to ground, then a long external reset re-reads it.
    strap_low = 1'b1;
    ext_rst = 1'b1;
    repeat (EXT_RST_CYC + 20) @(negedge clk_sys);
    check("ext reset drivers", {6'h00, sda_oe_r, int_oe, pin_oe}, 16'h0000);
    ext_rst = 1'b0;
    repeat (STRAP_CYC + 20) @(negedge clk_sys);
    dev = RST_ID_LO;
    rd("ground address", A_ID, RST_ID_LO);
    rd("ground mode", A_MODE, RST_MODE & 8'hFB);
    rd("ground sensitivity", A_SENS0 + 8'h05, {2'b00, SENS_GND});
    rd("config after reset", A_CFG, RST_CFG);
    // The untouched offset now lies above the ground threshold, so all channels count.
    measure(8'h00);
    rd("single touch", A_STAT, 8'h01);
    check("single pin", 16'(pin_oe), 16'h0001);
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    stop_test();
  end
endmodule // tb_top
